// [shared/cra_pkg.sv]
// Constants, modes and carriers shared by the core register and addressing block
package cra_pkg;

   // ----------------------------------------------------------------
   // Special function register offsets (direct addresses)
   // ----------------------------------------------------------------
   localparam logic [7:0] STACK_PTR_ADDR = 8'h81;
   localparam logic [7:0] DATA_PTR_LO_ADDR = 8'h82;
   localparam logic [7:0] DATA_PTR_HI_ADDR = 8'h83;
   localparam logic [7:0] STATUS_ADDR = 8'hD0;
   localparam logic [7:0] ACCUMULATOR_ADDR = 8'hE0;
   localparam logic [7:0] SECOND_OP_ADDR = 8'hF0;

   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic [7:0] STACK_PTR_RST = 8'h07;
   localparam logic [7:0] DATA_PTR_LO_RST = 8'h00;
   localparam logic [7:0] DATA_PTR_HI_RST = 8'h00;
   localparam logic [7:0] STATUS_RST = 8'h00;
   localparam logic [7:0] ACCUMULATOR_RST = 8'h00;
   localparam logic [7:0] SECOND_OP_RST = 8'h00;

   // ----------------------------------------------------------------
   // Status word bit positions
   // ----------------------------------------------------------------
   localparam int unsigned CARRY_BIT = 7;
   localparam int unsigned AUX_CARRY_BIT = 6;
   localparam int unsigned USER0_BIT = 5;
   localparam int unsigned BANK_HI_BIT = 4;
   localparam int unsigned BANK_LO_BIT = 3;
   localparam int unsigned OVERFLOW_BIT = 2;
   localparam int unsigned USER1_BIT = 1;
   localparam int unsigned PARITY_BIT = 0;

   // ----------------------------------------------------------------
   // Memory map
   // ----------------------------------------------------------------
   localparam logic [7:0] SFR_BASE = 8'h80;
   localparam logic [2:0] BANK_PAD = 3'h0;
   localparam int IRAM_SIZE = 256;
   localparam int XRAM_SIZE = 1792;
   localparam int XRAM_AW = 11;
   localparam logic [15:0] XRAM_LIMIT = 16'h0700;
   localparam logic [15:0] CODE_LIMIT = 16'h8000;

   // ----------------------------------------------------------------
   // Instruction timing, in system clocks
   // ----------------------------------------------------------------
   localparam logic [2:0] CYC_MIN = 3'h1;
   localparam logic [2:0] CYC_MAX = 3'h6;
   localparam logic [2:0] CYC_SAT = 3'h7;

   // ----------------------------------------------------------------
   // Access modes and sub-selections
   // ----------------------------------------------------------------
   typedef enum logic [3:0] {
      M_DIRECT = 4'h0,
      M_IND8 = 4'h1,
      M_PUSH = 4'h2,
      M_POP = 4'h3,
      M_REG = 4'h4,
      M_SPEC = 4'h5,
      M_IMM = 4'h6,
      M_IDX_DATA_POINTER = 4'h7,
      M_IDX_PC = 4'h8,
      M_JMP_IDX = 4'h9,
      M_XRAM = 4'hA,
      M_ALU = 4'hB,
      M_BOOL = 4'hC
   } cra_mode_e;

   localparam logic [2:0] SPEC_ACCUM = 3'h0;
   localparam logic [2:0] SPEC_SECOND = 3'h1;
   localparam logic [2:0] SPEC_PTR_LOAD = 3'h2;
   localparam logic [2:0] SPEC_PTR_INC = 3'h3;

   typedef enum logic [2:0] {
      BOP_CLR = 3'h0,
      BOP_SET = 3'h1,
      BOP_CPL = 3'h2,
      BOP_AND = 3'h3,
      BOP_OR = 3'h4,
      BOP_ANDN = 3'h5,
      BOP_ORN = 3'h6,
      BOP_MOV = 3'h7
   } cra_bop_e;

   // ----------------------------------------------------------------
   // Carriers
   // ----------------------------------------------------------------
   typedef struct packed {
      cra_mode_e mode;
      logic write;
      logic [2:0] sel;
      logic [7:0] addr;
      logic [7:0] wdata;
      logic [7:0] wdata_hi;
      logic [15:0] prog_counter;
   } cra_req_s;

   typedef struct packed {
      logic valid;
      logic err;
      logic [7:0] data;
      logic [15:0] addr;
   } cra_rsp_s;

   typedef struct packed {
      logic rd;
      logic [15:0] addr;
   } cra_code_s;

endpackage : cra_pkg

// [src/cra_core_regs.sv]
// Core register set, internal data memories and operand address generation
//
// Overview of operation
// - Parity flag tracks odd ones in accumulator
// - Two bank bits pick one of four banks
// - Push increments stack pointer, then writes byte
// - Stack pointer resets 07h, others zero
// - Data pointer built from low, high bytes
// - Data pointer addresses expanded RAM and code
// - Carry is the Boolean operand and result
// - Instructions take one to six clocks
// - Timing counted in plain system clocks
// - Direct 8-bit address reaches RAM, SFRs only
// - Indirect 8-bit uses R0, R1 or stack
// - Indirect 16-bit uses only the data pointer
// - Register mode: 3-bit field picks bank register
// - Indexed reads code at base plus accumulator
// - Indexed jump target is base plus accumulator
// - Code is read-only, at most 32K bytes
// - No external code fetch path exists
// - 256 bytes scratch-pad plus 1792 expanded RAM
// - Code and data are separate address spaces
// - Second operand register holds extra result byte
// - Immediate operand read from code after opcode
// - Register-specific modes imply target from opcode
// - Banks fill lowest 32 bytes, eight each
// - Above 7Fh: direct hits SFRs, indirect RAM
`timescale 1ns/1ns
module cra_core_regs
(
   input wire logic CLK_I,
   input wire logic ARST_N_I,
   input wire logic REQ_VALID_I,
   input wire cra_pkg::cra_req_s REQ_I,
   input wire logic INSTR_START_I,
   output cra_pkg::cra_rsp_s RSP_O,
   output cra_pkg::cra_code_s CODE_O,
   output logic [7:0] STATUS_WORD_O,
   output logic [7:0] ACCUMULATOR_O,
   output logic [7:0] SECOND_OPERAND_O,
   output logic [7:0] STACK_POINTER_O,
   output logic [15:0] DATA_POINTER_O,
   output logic [2:0] LAST_CYCLES_O,
   output logic TIMING_ERR_O
);
   import cra_pkg::*;

   // ----------------------------------------------------------------
   // Storage
   // ----------------------------------------------------------------
   logic [7:0] program_status_word_reg;
   logic [7:0] accumulator_reg;
   logic [7:0] second_operand_reg;
   logic [7:0] stack_pointer_reg;
   logic [7:0] data_pointer_low_reg;
   logic [7:0] data_pointer_high_reg;
   logic [7:0] iram [0:IRAM_SIZE-1];
   logic [7:0] xram [0:XRAM_SIZE-1];
   logic [2:0] cyc_cnt_reg;
   logic in_instr_reg;
   cra_rsp_s rsp_reg;
   cra_code_s code_reg;
   logic [2:0] last_cycles_reg;
   logic timing_err_reg;

   // ----------------------------------------------------------------
   // Decode results
   // ----------------------------------------------------------------
   logic [1:0] bank;
   logic [15:0] data_pointer;
   logic [7:0] ptr_addr;
   logic [7:0] acc_next;
   logic iram_we;
   logic [7:0] iram_wa;
   logic xram_we;
   logic sfr_we;
   logic sp_push;
   logic sp_pop;
   logic second_we;
   logic ptr_load;
   logic ptr_inc;
   logic [2:0] flag_we;
   logic bool_we;
   logic carry_new;
   cra_rsp_s rsp_next;
   cra_code_s code_next;

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   function automatic logic [7:0] bank_reg_addr(input logic [1:0] bk, input logic [2:0] idx);
      return {BANK_PAD, bk, idx};
   endfunction : bank_reg_addr

   function automatic logic sfr_hit(input logic [7:0] a);
      return (a == STACK_PTR_ADDR) || (a == DATA_PTR_LO_ADDR) || (a == DATA_PTR_HI_ADDR) ||
             (a == STATUS_ADDR) || (a == ACCUMULATOR_ADDR) || (a == SECOND_OP_ADDR);
   endfunction : sfr_hit

   function automatic logic [15:0] plus_accum(input logic [15:0] base, input logic [7:0] a);
      return base + {8'h00, a};
   endfunction : plus_accum

   assign bank = {program_status_word_reg[BANK_HI_BIT], program_status_word_reg[BANK_LO_BIT]};
   assign data_pointer = {data_pointer_high_reg, data_pointer_low_reg};
   // Pointer register R0 or R1 of the active bank
   assign ptr_addr = iram[bank_reg_addr(bank, {2'h0, REQ_I.sel[0]})];

   // ----------------------------------------------------------------
   // Access decode
   // ----------------------------------------------------------------
   always_comb
   begin
      iram_we = 1'b0;
      iram_wa = REQ_I.addr;
      xram_we = 1'b0;
      sfr_we = 1'b0;
      sp_push = 1'b0;
      sp_pop = 1'b0;
      second_we = 1'b0;
      ptr_load = 1'b0;
      ptr_inc = 1'b0;
      flag_we = 3'h0;
      bool_we = 1'b0;
      carry_new = program_status_word_reg[CARRY_BIT];
      acc_next = accumulator_reg;
      rsp_next = '0;
      code_next = '0;
      rsp_next.valid = REQ_VALID_I;
      if (REQ_VALID_I)
      begin
         unique case (REQ_I.mode)
            M_DIRECT:
            begin
               // Same 8-bit field lands in RAM below 80h and in SFRs above
               if (REQ_I.addr < SFR_BASE)
               begin
                  rsp_next.data = iram[REQ_I.addr];
                  iram_we = REQ_I.write;
               end
               else
               begin
                  rsp_next.err = !sfr_hit(REQ_I.addr);
                  sfr_we = REQ_I.write && sfr_hit(REQ_I.addr);
                  unique case (REQ_I.addr)
                     STACK_PTR_ADDR: rsp_next.data = stack_pointer_reg;
                     DATA_PTR_LO_ADDR: rsp_next.data = data_pointer_low_reg;
                     DATA_PTR_HI_ADDR: rsp_next.data = data_pointer_high_reg;
                     STATUS_ADDR: rsp_next.data = program_status_word_reg;
                     ACCUMULATOR_ADDR: rsp_next.data = accumulator_reg;
                     SECOND_OP_ADDR: rsp_next.data = second_operand_reg;
                     default: rsp_next.data = 8'h00;
                  endcase
                  if (REQ_I.write && REQ_I.addr == ACCUMULATOR_ADDR)
                  begin
                     acc_next = REQ_I.wdata;
                  end
               end
               rsp_next.addr = {8'h00, REQ_I.addr};
            end
            M_IND8:
            begin
               // Upper half here is plain RAM, not the SFR space
               rsp_next.data = iram[ptr_addr];
               iram_wa = ptr_addr;
               iram_we = REQ_I.write;
               rsp_next.addr = {8'h00, ptr_addr};
            end
            M_PUSH:
            begin
               iram_wa = stack_pointer_reg + 8'h01;
               iram_we = 1'b1;
               sp_push = 1'b1;
               rsp_next.addr = {8'h00, iram_wa};
            end
            M_POP:
            begin
               rsp_next.data = iram[stack_pointer_reg];
               sp_pop = 1'b1;
               rsp_next.addr = {8'h00, stack_pointer_reg};
            end
            M_REG:
            begin
               iram_wa = bank_reg_addr(bank, REQ_I.sel);
               rsp_next.data = iram[iram_wa];
               iram_we = REQ_I.write;
               rsp_next.addr = {8'h00, iram_wa};
            end
            M_SPEC:
            begin
               unique case (REQ_I.sel)
                  SPEC_ACCUM:
                  begin
                     rsp_next.data = accumulator_reg;
                     if (REQ_I.write)
                     begin
                        acc_next = REQ_I.wdata;
                     end
                  end
                  SPEC_SECOND:
                  begin
                     rsp_next.data = second_operand_reg;
                     second_we = REQ_I.write;
                  end
                  SPEC_PTR_LOAD:
                  begin
                     rsp_next.addr = data_pointer;
                     ptr_load = REQ_I.write;
                  end
                  SPEC_PTR_INC:
                  begin
                     rsp_next.addr = data_pointer;
                     ptr_inc = 1'b1;
                  end
                  default: rsp_next.err = 1'b1;
               endcase
            end
            M_IMM:
            begin
               // Constant sits in the code byte after the opcode
               rsp_next.addr = REQ_I.prog_counter + 16'h0001;
               rsp_next.err = REQ_I.write || (rsp_next.addr >= CODE_LIMIT);
               code_next.rd = !rsp_next.err;
               code_next.addr = rsp_next.addr;
            end
            M_IDX_DATA_POINTER, M_IDX_PC:
            begin
               rsp_next.addr = plus_accum((REQ_I.mode == M_IDX_DATA_POINTER) ? data_pointer : REQ_I.prog_counter,
                                          accumulator_reg);
               // A write here is refused: code space is never written, and all of it is on chip
               rsp_next.err = REQ_I.write || (rsp_next.addr >= CODE_LIMIT);
               code_next.rd = !rsp_next.err;
               code_next.addr = rsp_next.addr;
            end
            M_JMP_IDX:
            begin
               rsp_next.addr = plus_accum(data_pointer, accumulator_reg);
               rsp_next.err = rsp_next.addr >= CODE_LIMIT;
            end
            M_XRAM:
            begin
               // Only the data pointer can form a 16-bit data address
               rsp_next.addr = data_pointer;
               rsp_next.err = data_pointer >= XRAM_LIMIT;
               xram_we = REQ_I.write && !rsp_next.err;
               if (!rsp_next.err)
               begin
                  rsp_next.data = xram[data_pointer[XRAM_AW-1:0]];
               end
            end
            M_ALU:
            begin
               acc_next = REQ_I.wdata;
               second_we = REQ_I.write;
               flag_we = REQ_I.sel;
               rsp_next.data = REQ_I.wdata;
            end
            M_BOOL:
            begin
               bool_we = 1'b1;
               unique case (cra_bop_e'(REQ_I.sel))
                  BOP_CLR: carry_new = 1'b0;
                  BOP_SET: carry_new = 1'b1;
                  BOP_CPL: carry_new = !program_status_word_reg[CARRY_BIT];
                  BOP_AND: carry_new = program_status_word_reg[CARRY_BIT] & REQ_I.wdata[0];
                  BOP_OR: carry_new = program_status_word_reg[CARRY_BIT] | REQ_I.wdata[0];
                  BOP_ANDN: carry_new = program_status_word_reg[CARRY_BIT] & !REQ_I.wdata[0];
                  BOP_ORN: carry_new = program_status_word_reg[CARRY_BIT] | !REQ_I.wdata[0];
                  BOP_MOV: carry_new = REQ_I.wdata[0];
               endcase
               rsp_next.data = {7'h00, carry_new};
            end
            default: rsp_next.err = 1'b1;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Accumulator
   // ----------------------------------------------------------------
   always_ff @(posedge CLK_I or negedge ARST_N_I)
   begin
      if (!ARST_N_I)
         accumulator_reg <= ACCUMULATOR_RST;
      else
         accumulator_reg <= acc_next;
   end

   // ----------------------------------------------------------------
   // Second operand register
   // ----------------------------------------------------------------
   always_ff @(posedge CLK_I or negedge ARST_N_I)
   begin
      if (!ARST_N_I)
         second_operand_reg <= SECOND_OP_RST;
      else if (second_we)
         second_operand_reg <= (REQ_I.mode == M_ALU) ? REQ_I.wdata_hi : REQ_I.wdata;
      else if (sfr_we && REQ_I.addr == SECOND_OP_ADDR)
         second_operand_reg <= REQ_I.wdata;
   end

   // ----------------------------------------------------------------
   // Stack pointer
   // ----------------------------------------------------------------
   always_ff @(posedge CLK_I or negedge ARST_N_I)
   begin
      if (!ARST_N_I)
         stack_pointer_reg <= STACK_PTR_RST;
      else if (sp_push)
         stack_pointer_reg <= stack_pointer_reg + 8'h01;
      else if (sp_pop)
         stack_pointer_reg <= stack_pointer_reg - 8'h01;
      else if (sfr_we && REQ_I.addr == STACK_PTR_ADDR)
         stack_pointer_reg <= REQ_I.wdata;
   end

   // ----------------------------------------------------------------
   // Data pointer bytes
   // ----------------------------------------------------------------
   always_ff @(posedge CLK_I or negedge ARST_N_I)
   begin
      if (!ARST_N_I)
      begin
         data_pointer_low_reg <= DATA_PTR_LO_RST;
         data_pointer_high_reg <= DATA_PTR_HI_RST;
      end
      else if (ptr_load)
      begin
         data_pointer_low_reg <= REQ_I.wdata;
         data_pointer_high_reg <= REQ_I.wdata_hi;
      end
      else if (ptr_inc)
         {data_pointer_high_reg, data_pointer_low_reg} <= data_pointer + 16'h0001;
      else if (sfr_we && REQ_I.addr == DATA_PTR_LO_ADDR)
         data_pointer_low_reg <= REQ_I.wdata;
      else if (sfr_we && REQ_I.addr == DATA_PTR_HI_ADDR)
         data_pointer_high_reg <= REQ_I.wdata;
   end

   // ----------------------------------------------------------------
   // Status word
   // ----------------------------------------------------------------
   // Parity is rebuilt every clock from the next accumulator, so a software write cannot corrupt it
   always_ff @(posedge CLK_I or negedge ARST_N_I)
   begin
      if (!ARST_N_I)
         program_status_word_reg <= STATUS_RST;
      else
      begin
         program_status_word_reg[PARITY_BIT] <= ^acc_next;
         if (sfr_we && REQ_I.addr == STATUS_ADDR)
            program_status_word_reg[CARRY_BIT:USER1_BIT] <= REQ_I.wdata[CARRY_BIT:USER1_BIT];
         else if (bool_we)
            program_status_word_reg[CARRY_BIT] <= carry_new;
         else
         begin
            if (flag_we[0])
               program_status_word_reg[CARRY_BIT] <= REQ_I.addr[CARRY_BIT];
            if (flag_we[1])
               program_status_word_reg[AUX_CARRY_BIT] <= REQ_I.addr[AUX_CARRY_BIT];
            if (flag_we[2])
               program_status_word_reg[OVERFLOW_BIT] <= REQ_I.addr[OVERFLOW_BIT];
         end
      end
   end

   // ----------------------------------------------------------------
   // Data memories (no reset: contents are undefined at power up)
   // ----------------------------------------------------------------
   always_ff @(posedge CLK_I)
   begin
      if (iram_we)
         iram[iram_wa] <= REQ_I.wdata;
   end

   always_ff @(posedge CLK_I)
   begin
      if (xram_we)
         xram[data_pointer[XRAM_AW-1:0]] <= REQ_I.wdata;
   end

   // ----------------------------------------------------------------
   // Answer and code read strobe
   // ----------------------------------------------------------------
   always_ff @(posedge CLK_I or negedge ARST_N_I)
   begin
      if (!ARST_N_I)
      begin
         rsp_reg <= '0;
         code_reg <= '0;
      end
      else
      begin
         rsp_reg <= rsp_next;
         code_reg <= code_next;
      end
   end

   // ----------------------------------------------------------------
   // Instruction clock count
   // ----------------------------------------------------------------
   // One count per system clock; no machine-cycle prescale exists
   always_ff @(posedge CLK_I or negedge ARST_N_I)
   begin
      if (!ARST_N_I)
      begin
         cyc_cnt_reg <= CYC_MIN;
         in_instr_reg <= 1'b0;
         last_cycles_reg <= 3'h0;
         timing_err_reg <= 1'b0;
      end
      else if (INSTR_START_I)
      begin
         cyc_cnt_reg <= CYC_MIN;
         in_instr_reg <= 1'b1;
         if (in_instr_reg)
         begin
            last_cycles_reg <= cyc_cnt_reg;
            timing_err_reg <= (cyc_cnt_reg < CYC_MIN) || (cyc_cnt_reg > CYC_MAX);
         end
      end
      else if (in_instr_reg && cyc_cnt_reg != CYC_SAT)
         cyc_cnt_reg <= cyc_cnt_reg + 3'h1;
   end

   assign RSP_O = rsp_reg;
   assign CODE_O = code_reg;
   assign STATUS_WORD_O = program_status_word_reg;
   assign ACCUMULATOR_O = accumulator_reg;
   assign SECOND_OPERAND_O = second_operand_reg;
   assign STACK_POINTER_O = stack_pointer_reg;
   assign DATA_POINTER_O = data_pointer;
   assign LAST_CYCLES_O = last_cycles_reg;
   assign TIMING_ERR_O = timing_err_reg;

endmodule : cra_core_regs

// [sim/cra_core_regs_sva.sv]
// Assertion checker for the core register and addressing block
`timescale 1ns/1ns
module cra_core_regs_sva
   import cra_pkg::*;
(
   input wire logic CLK_I,
   input wire logic ARST_N_I,
   input wire logic REQ_VALID_I,
   input wire cra_pkg::cra_req_s REQ_I,
   input wire logic INSTR_START_I,
   input wire cra_pkg::cra_rsp_s RSP_O,
   input wire cra_pkg::cra_code_s CODE_O,
   input wire logic [7:0] STATUS_WORD_O,
   input wire logic [7:0] ACCUMULATOR_O,
   input wire logic [7:0] STACK_POINTER_O,
   input wire logic [15:0] DATA_POINTER_O,
   input wire logic [2:0] LAST_CYCLES_O,
   input wire logic TIMING_ERR_O
);
   logic [3:0] m;
   logic [15:0] idx;
   // Idle cycles map to an illegal mode so that no mode-based antecedent fires
   assign m = REQ_VALID_I ? REQ_I.mode : 4'hF;
   assign idx = DATA_POINTER_O + {8'h00, ACCUMULATOR_O};
   default clocking cb @(posedge CLK_I); endclocking
   default disable iff (!ARST_N_I);
   // ------
   // Checks
   // ------
   AST_PARITY: assert property (STATUS_WORD_O[0] == ^ACCUMULATOR_O)
      else $error("parity flag wrong");
   AST_RESET: assert property ($rose(ARST_N_I) |-> STACK_POINTER_O == STACK_PTR_RST && DATA_POINTER_O == 16'h0000)
      else $error("reset value wrong");
   AST_PUSH: assert property (m == M_PUSH |=> STACK_POINTER_O == $past(STACK_POINTER_O) + 8'h01
      && RSP_O.addr == {8'h00, STACK_POINTER_O}) else $error("push order wrong");
   AST_IDX: assert property (m == M_IDX_DATA_POINTER && !REQ_I.write |=> RSP_O.err || CODE_O.rd && CODE_O.addr == $past(idx))
      else $error("indexed address wrong");
   AST_JMP: assert property (m == M_JMP_IDX |=> RSP_O.addr == $past(idx))
      else $error("jump target wrong");
   AST_IMM: assert property (m == M_IMM && !REQ_I.write |=> RSP_O.err || CODE_O.addr == $past(REQ_I.prog_counter) + 16'h0001)
      else $error("immediate address wrong");
   AST_CODE_LIMIT: assert property (CODE_O.rd |-> CODE_O.addr < CODE_LIMIT)
      else $error("code read beyond limit");
   AST_TIMING: assert property (INSTR_START_I ##1 INSTR_START_I |=> LAST_CYCLES_O == 3'h1 && !TIMING_ERR_O)
      else $error("cycle count wrong");
   COV_PUSH: cover property (m == M_PUSH);
   COV_CODE: cover property (CODE_O.rd);
   COV_TERR: cover property (TIMING_ERR_O);
endmodule : cra_core_regs_sva

// [sim/cra_flash_model.sv]
// Behavioural program flash answering code reads
`timescale 1ns/1ns
module cra_flash_model
(
   input wire logic clk_i,
   input wire cra_pkg::cra_code_s code_i,
   output logic [7:0] data_o,
   output int reads_o
);
   initial reads_o = 0;
   initial data_o = 8'h00;
   // No write port: the flash is read-only; idle cycles show a changing byte
   always @(posedge clk_i)
   begin
      if (code_i.rd)
      begin
         data_o <= code_i.addr[7:0] ^ 8'hA5;
         reads_o <= reads_o + 1;
      end
      else
         data_o <= ~data_o;
   end
endmodule : cra_flash_model

// [sim/testbench.sv]
// Self-checking testbench for the core register and addressing block
`timescale 1ns/1ns
module testbench;
   import cra_pkg::*;
   logic clk, arst_n, vld, start, terr;
   logic [7:0] sw, acc, sec, sp, fdata;
   logic [15:0] dp;
   logic [2:0] cyc;
   cra_req_s req;
   cra_rsp_s rsp, rsp_w;
   cra_code_s code, code_w;
   int freads, num_errors = 0, compares = 0;
   logic [7:0] sfa [6] = '{8'h81, 8'h82, 8'h83, 8'hD0, 8'hE0, 8'hF0};
   logic [7:0] pat [6] = '{8'h2F, 8'h11, 8'h22, 8'h41, 8'h07, 8'h99};
   logic [7:0] bsel = 8'h38, bexp = 8'h52;
   cra_core_regs dut (.CLK_I(clk), .ARST_N_I(arst_n), .REQ_VALID_I(vld), .REQ_I(req), .INSTR_START_I(start),
      .RSP_O(rsp_w), .CODE_O(code_w), .STATUS_WORD_O(sw), .ACCUMULATOR_O(acc), .SECOND_OPERAND_O(sec),
      .STACK_POINTER_O(sp), .DATA_POINTER_O(dp), .LAST_CYCLES_O(cyc), .TIMING_ERR_O(terr));
   cra_flash_model flash (.clk_i(clk), .code_i(code_w), .data_o(fdata), .reads_o(freads));
   // ------
   // Tasks
   // ------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   task automatic xfer(input cra_mode_e m, input logic w, input logic [2:0] s, input logic [7:0] a, d, dh,
      input logic [15:0] pc);
      @(posedge clk);
      req <= '{m, w, s, a, d, dh, pc};
      vld <= 1'b1;
      @(posedge clk);
      vld <= 1'b0;
      #1;
      rsp = rsp_w;
      code = code_w;
   endtask : xfer
   task automatic gap(input int n, input logic [3:0] e);
      repeat (n - 1) @(posedge clk);
      start <= 1'b1;
      @(posedge clk);
      start <= 1'b0;
      #1;
      check({terr, cyc}, e);
   endtask : gap
   task automatic summarize();
      if (num_errors == 0 && compares > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : summarize
   // ------
   // Sequence
   // ------
   initial
   begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   initial
   begin
      repeat (3000) @(posedge clk);
      num_errors++;
      summarize();
   end
   initial
   begin
      arst_n = 1'b0;
      vld = 1'b0;
      start = 1'b0;
      req = '0;
      repeat (12) @(posedge clk);
      arst_n <= 1'b1;
      for (int i = 0; i < 6; i++)
      begin
         xfer(M_DIRECT, 0, 0, sfa[i], 0, 0, 0);
         check(rsp.data, i == 0 ? 8'h07 : 8'h00);
      end
      for (int i = 0; i < 6; i++)
         xfer(M_DIRECT, 1, 0, sfa[i], pat[i], 0, 0);
      for (int i = 0; i < 6; i++)
      begin
         xfer(M_DIRECT, 0, 0, sfa[i], 0, 0, 0);
         check(rsp.data, pat[i]);
      end
      xfer(M_DIRECT, 0, 0, 8'h85, 0, 0, 0);
      check({rsp.valid, rsp.err, rsp.data}, 10'h300);
      xfer(M_PUSH, 1, 0, 0, 8'h5A, 0, 0);
      check({sp, rsp.addr}, 24'h300030);
      xfer(M_DIRECT, 0, 0, 8'h30, 0, 0, 0);
      check(rsp.data, 8'h5A);
      for (int b = 0; b < 4; b++)
      begin
         xfer(M_DIRECT, 1, 0, 8'hD0, {3'h0, 2'(b), 3'h0}, 0, 0);
         xfer(M_REG, 1, 3'h5, 0, 8'h60 + 8'(b), 0, 0);
         xfer(M_REG, 1, 3'h0, 0, 8'h90 + 8'(b), 0, 0);
         xfer(M_IND8, 1, 3'h0, 0, 8'hC0 + 8'(b), 0, 0);
         xfer(M_DIRECT, 0, 0, 8'(b * 8 + 5), 0, 0, 0);
         check(rsp.data, 8'h60 + 8'(b));
         xfer(M_IND8, 0, 3'h0, 0, 0, 0, 0);
         check({rsp.addr, rsp.data}, {8'h00, 8'h90 + 8'(b), 8'hC0 + 8'(b)});
      end
      xfer(M_POP, 0, 0, 0, 0, 0, 0);
      check({sp, rsp.data}, 16'h2F5A);
      xfer(M_SPEC, 1, SPEC_PTR_LOAD, 0, 8'h34, 8'h12, 0);
      xfer(M_SPEC, 1, SPEC_ACCUM, 0, 8'h10, 0, 0);
      check(dp, 16'h1234);
      xfer(M_IDX_DATA_POINTER, 0, 0, 0, 0, 0, 0);
      check({code.rd, code.addr}, 17'h11244);
      xfer(M_JMP_IDX, 0, 0, 0, 0, 0, 0);
      check(rsp.addr, 16'h1244);
      xfer(M_IDX_PC, 0, 0, 0, 0, 0, 16'h7FF8);
      check({rsp.err, code.rd}, 2'b10);
      xfer(M_IMM, 0, 0, 0, 0, 0, 16'h0100);
      check({code.rd, code.addr}, 17'h10101);
      @(posedge clk);
      #1;
      check(fdata, 8'h01 ^ 8'hA5);
      xfer(M_IDX_DATA_POINTER, 1, 0, 0, 0, 0, 0);
      check({rsp.err, code.rd}, 2'b10);
      xfer(M_XRAM, 1, 0, 0, 8'h3C, 0, 0);
      check(rsp.err, 1'b1);
      xfer(M_SPEC, 1, SPEC_PTR_LOAD, 0, 8'hFF, 8'h06, 0);
      xfer(M_XRAM, 1, 0, 0, 8'h3C, 0, 0);
      xfer(M_XRAM, 0, 0, 0, 0, 0, 0);
      check({rsp.err, rsp.data}, 9'h03C);
      xfer(M_SPEC, 1, SPEC_PTR_INC, 0, 0, 0, 0);
      xfer(M_XRAM, 0, 0, 0, 0, 0, 0);
      check({rsp.err, dp}, 17'h10700);
      check(freads, 2);
      xfer(M_ALU, 1, 3'h7, 8'hC4, 8'h0F, 8'hE1, 0);
      check({sw[7:6], sw[2], acc, sec}, 19'h70FE1);
      for (int i = 0; i < 8; i++)
      begin
         xfer(M_BOOL, 1, 3'(i), 0, {7'h00, bsel[i]}, 0, 0);
         check({rsp.data, sw[7]}, {7'h00, bexp[i], bexp[i]});
      end
      gap(1, 4'h0);
      gap(1, 4'h1);
      gap(6, 4'h6);
      gap(7, 4'hF);
      gap(2, 4'h2);
      summarize();
   end
endmodule : testbench
bind cra_core_regs cra_core_regs_sva chk_i (.CLK_I, .ARST_N_I, .REQ_VALID_I, .REQ_I, .INSTR_START_I, .RSP_O,
   .CODE_O, .STATUS_WORD_O, .ACCUMULATOR_O, .STACK_POINTER_O, .DATA_POINTER_O, .LAST_CYCLES_O, .TIMING_ERR_O);
